// ---- core/arcc_data_flag.sv ----
`timescale 1ns/10ps
// One channel's data-available flag.
module arcc_data_flag (
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic enable_in,
   input wire logic done_in,
   input wire logic clear_in,
   output logic flag_out
);

   // The set wins over a clear in the same cycle so no sample is lost.
   // A disabled channel keeps no flag at all.
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         flag_out <= 1'b0;
      end else if (!enable_in) begin
         flag_out <= 1'b0;
      end else if (done_in) begin
         flag_out <= 1'b1;
      end else if (clear_in) begin
         flag_out <= 1'b0;
      end
   end

endmodule

// ---- core/arcc_map.svh ----
// How it works
// - Select code 00b, the reset value, drives the ready pin from the enabled channel that finishes last.
// - Select code 01b drives the ready pin from the OR of the data flags of all enabled channels.
// - Select codes 10b and 11b drive the ready pin from the enabled channel that finishes first.
// - With no data available the pin idles high when the float bit is 0b and floats when it is 1b.
// - On new data the pin goes low and stays low for format 0b, or gives a fixed low pulse for 1b.
// - Clock register bit 9 enables channel one and resets to 1b.
// - Clock register bit 8 enables channel zero and resets to 1b.
// - The turbo bit, bit 5, forces a ratio of 64 whatever the ratio field holds.
// - The ratio field maps 000b..111b to 128..8192 and 16256, and resets to 011b.
// - The power field gives very-low-power for 00b, low-power for 01b, high-resolution otherwise.
// - Clock register bits 15 to 10 are read-only and read as zero.
// - The clock register sits at index 3h and resets to 030Eh.
// - The mode register sits at index 2h and resets to 0510h.
// - The status register shows one data flag per channel, bit 0 and bit 1.
`ifndef ARCC_MAP_SVH
`define ARCC_MAP_SVH

// Register indices; the bus byte address is four times the index.
`define ARCC_IDX_STATUS 4'h1
`define ARCC_IDX_MODE 4'h2
`define ARCC_IDX_CLOCK 4'h3
`define ARCC_ADDR_STATUS {2'b00, `ARCC_IDX_STATUS, 2'b00}
`define ARCC_ADDR_MODE {2'b00, `ARCC_IDX_MODE, 2'b00}
`define ARCC_ADDR_CLOCK {2'b00, `ARCC_IDX_CLOCK, 2'b00}

// Reset values and masks.
`define ARCC_MODE_RST 16'h0510
`define ARCC_CLOCK_RST 16'h030e
`define ARCC_CLOCK_RW_MASK 16'h03ff

// Field positions.
`define ARCC_SEL_HI 3
`define ARCC_SEL_LO 2
`define ARCC_HIZ_BIT 1
`define ARCC_FMT_BIT 0
`define ARCC_CHANNEL_ONE_ENABLE_BIT 9
`define ARCC_CHANNEL_ZERO_ENABLE_BIT 8
`define ARCC_TBM_BIT 5
`define ARCC_OSR_HI 4
`define ARCC_OSR_LO 2
`define ARCC_PWR_HI 1
`define ARCC_PWR_LO 0

// Oversampling ratios.
`define ARCC_OSR_TURBO 15'h0040
`define ARCC_OSR_0 15'h0080
`define ARCC_OSR_1 15'h0100
`define ARCC_OSR_2 15'h0200
`define ARCC_OSR_3 15'h0400
`define ARCC_OSR_4 15'h0800
`define ARCC_OSR_5 15'h1000
`define ARCC_OSR_6 15'h2000
`define ARCC_OSR_7 15'h3f80

// Bus answers.
`define ARCC_RESP_OKAY 2'h0
`define ARCC_RESP_SLVERR 2'h2

// Fixed low pulse width of the ready pin in ns, and its cycle count.
`define ARCC_CLK_NS 20
`define ARCC_PULSE_NS 40
`define ARCC_PULSE_CYC ((`ARCC_PULSE_NS + `ARCC_CLK_NS - 1) / `ARCC_CLK_NS)

`endif

// ---- core/arcc_pkg.sv ----
package arcc_pkg;

   // Effective source of the ready pin.
   typedef enum logic [1:0] {
      ARCC_SRC_LAG,
      ARCC_SRC_OR,
      ARCC_SRC_LEAD
   } arcc_rdy_src_t;

   // Effective power mode.
   typedef enum logic [1:0] {
      ARCC_PWR_VLP,
      ARCC_PWR_LP,
      ARCC_PWR_HR
   } arcc_pwr_t;

   // Ready pin sequencer states.
   typedef enum logic [1:0] {
      ARCC_PIN_IDLE,
      ARCC_PIN_HOLD,
      ARCC_PIN_PULSE,
      ARCC_PIN_SPENT
   } arcc_pin_st_t;

endpackage

// ---- core/arcc_ready_pin.sv ----
`timescale 1ns/10ps
`include "arcc_map.svh"
// Shapes the conversion-ready pin from a data-available level.
module arcc_ready_pin
   import arcc_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic avail_in,
   input wire logic pulse_fmt_in,
   input wire logic idle_float_in,
   output logic pin_out,
   output logic pin_oe_out
);

   arcc_pin_st_t state_r;
   logic [7:0] cnt_r;
   logic active_low;

   // State sequence: a pulse ends in SPENT until the level drops again.
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         state_r <= ARCC_PIN_IDLE;
      end else begin
         case (state_r)
            ARCC_PIN_IDLE: begin
               if (avail_in && pulse_fmt_in) begin
                  state_r <= ARCC_PIN_PULSE;
               end else if (avail_in) begin
                  state_r <= ARCC_PIN_HOLD;
               end
            end
            ARCC_PIN_HOLD: begin
               if (!avail_in) begin
                  state_r <= ARCC_PIN_IDLE;
               end
            end
            ARCC_PIN_PULSE: begin
               if (cnt_r == 8'(`ARCC_PULSE_CYC - 1)) begin
                  state_r <= avail_in ? ARCC_PIN_SPENT : ARCC_PIN_IDLE;
               end
            end
            ARCC_PIN_SPENT: begin
               if (!avail_in) begin
                  state_r <= ARCC_PIN_IDLE;
               end
            end
            default: begin
               state_r <= ARCC_PIN_IDLE;
            end
         endcase
      end
   end

   // Pulse width counter, restarted on every entry to the pulse.
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in || state_r != ARCC_PIN_PULSE) begin
         cnt_r <= 8'h00;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end

   assign active_low = (state_r == ARCC_PIN_HOLD) ||
                       (state_r == ARCC_PIN_PULSE);

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         pin_out <= 1'b1;
         pin_oe_out <= 1'b1;
      end else begin
         pin_out <= !active_low;
         pin_oe_out <= active_low || !idle_float_in;
      end
   end

endmodule

// ---- core/arcc_top.sv ----
`timescale 1ns/10ps
`include "arcc_map.svh"
// Ready-pin and clock configuration bank behind an AXI4-Lite slave.
module arcc_top
   import arcc_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // AXI4-Lite write address channel.
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   // AXI4-Lite write data channel.
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   // AXI4-Lite write response channel.
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // AXI4-Lite read address channel.
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   // AXI4-Lite read data channel.
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // Converter datapath events.
   input wire logic [1:0] conv_done_in,
   input wire logic data_read_in,
   // Conversion-ready pin as output and output enable.
   output logic conversion_ready_pin_out,
   output logic conversion_ready_pin_oe_out,
   // Configuration and data flags seen by the converter.
   output logic [1:0] channel_enable_out,
   output logic [14:0] osr_ratio_out,
   output logic [1:0] power_mode_out,
   output logic [1:0] data_flag_out
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations.

   logic [15:0] ready_pin_mode_config_r;
   logic [15:0] clock_channel_rate_config_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic aw_held_r;
   logic w_held_r;
   logic do_write;
   logic [15:0] wr_mask;
   logic [15:0] wr_bits;
   logic [31:0] rd_data_nxt;
   logic [1:0] rd_resp_nxt;
   logic [1:0] chan_en;
   logic [1:0] flags;
   logic [1:0] live;
   logic lead_valid_r;
   logic lead_ch_r;
   logic avail;
   logic [14:0] osr_nxt;
   arcc_rdy_src_t src_sel;
   arcc_pwr_t pwr_sel;

   ////////////////////////////////////////////////////////////////////////
   // Write path: address and data are taken independently and may come
   // in either order; the register write happens once both are held.

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
      end else if (s_axi_awvalid_in && s_axi_awready_out) begin
         aw_held_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr_in;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         w_held_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else if (s_axi_wvalid_in && s_axi_wready_out) begin
         w_held_r <= 1'b1;
         w_data_r <= s_axi_wdata_in;
         w_strb_r <= s_axi_wstrb_in;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
         w_held_r <= 1'b0;
      end
   end

   // Each ready drops on its own handshake and returns with the response,
   // so only one write is ever in flight.
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         s_axi_awready_out <= 1'b1;
      end else if (s_axi_awvalid_in && s_axi_awready_out) begin
         s_axi_awready_out <= 1'b0;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
         s_axi_awready_out <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         s_axi_wready_out <= 1'b1;
      end else if (s_axi_wvalid_in && s_axi_wready_out) begin
         s_axi_wready_out <= 1'b0;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
         s_axi_wready_out <= 1'b1;
      end
   end

   assign do_write = aw_held_r && w_held_r && !s_axi_bvalid_out;

   // Only the two low byte lanes carry register bits.
   assign wr_mask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
   assign wr_bits = w_data_r[15:0];

   // Write response; an unmapped or read-only address answers SLVERR.
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `ARCC_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid_out <= 1'b1;
         if (aw_addr_r == `ARCC_ADDR_MODE ||
             aw_addr_r == `ARCC_ADDR_CLOCK) begin
            s_axi_bresp_out <= `ARCC_RESP_OKAY;
         end else begin
            s_axi_bresp_out <= `ARCC_RESP_SLVERR;
         end
      end else if (s_axi_bready_in) begin
         s_axi_bvalid_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers.

   // mode register at index 2h
   // All sixteen bits are stored; only the low four steer this block.
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         ready_pin_mode_config_r <= `ARCC_MODE_RST;
      end else if (do_write && aw_addr_r == `ARCC_ADDR_MODE) begin
         ready_pin_mode_config_r <= (ready_pin_mode_config_r & ~wr_mask) |
                                    (wr_bits & wr_mask);
      end
   end

   // top bits never stored
   // Bits 7 and 6 keep what the host writes; it is expected to write zero.
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         clock_channel_rate_config_r <= `ARCC_CLOCK_RST;
      end else if (do_write && aw_addr_r == `ARCC_ADDR_CLOCK) begin
         clock_channel_rate_config_r <=
            ((clock_channel_rate_config_r & ~wr_mask) |
             (wr_bits & wr_mask)) & `ARCC_CLOCK_RW_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path: the answer is registered one cycle after the address.

   always_comb begin
      rd_data_nxt = 32'h0000_0000;
      rd_resp_nxt = `ARCC_RESP_OKAY;
      case (s_axi_araddr_in)
         `ARCC_ADDR_STATUS: begin
            rd_data_nxt = {30'h0000_0000, flags};
         end
         `ARCC_ADDR_MODE: begin
            rd_data_nxt = {16'h0000, ready_pin_mode_config_r};
         end
         `ARCC_ADDR_CLOCK: begin
            rd_data_nxt = {16'h0000,
                           clock_channel_rate_config_r & `ARCC_CLOCK_RW_MASK};
         end
         default: begin
            rd_resp_nxt = `ARCC_RESP_SLVERR;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         s_axi_arready_out <= 1'b1;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= `ARCC_RESP_OKAY;
      end else if (s_axi_arvalid_in && s_axi_arready_out) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b1;
         s_axi_rdata_out <= rd_data_nxt;
         s_axi_rresp_out <= rd_resp_nxt;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
         s_axi_arready_out <= 1'b1;
         s_axi_rvalid_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel enables and data flags.

   assign chan_en[0] = clock_channel_rate_config_r[`ARCC_CHANNEL_ZERO_ENABLE_BIT];
   assign chan_en[1] = clock_channel_rate_config_r[`ARCC_CHANNEL_ONE_ENABLE_BIT];

   arcc_data_flag u_flag0 (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .enable_in(chan_en[0]),
      .done_in(conv_done_in[0]),
      .clear_in(data_read_in),
      .flag_out(flags[0])
   );

   arcc_data_flag u_flag1 (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .enable_in(chan_en[1]),
      .done_in(conv_done_in[1]),
      .clear_in(data_read_in),
      .flag_out(flags[1])
   );

   assign live = flags & chan_en;

   ////////////////////////////////////////////////////////////////////////
   // Ready source selection.

   always_comb begin
      case (ready_pin_mode_config_r[`ARCC_SEL_HI:`ARCC_SEL_LO])
         2'b00: src_sel = ARCC_SRC_LAG;
         2'b01: src_sel = ARCC_SRC_OR;
         default: src_sel = ARCC_SRC_LEAD;
      endcase
   end

   // Remember which enabled channel finished first in the current round.
   // Both finishing together counts channel zero as the leader.
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         lead_valid_r <= 1'b0;
         lead_ch_r <= 1'b0;
      end else if (live == 2'b00) begin
         lead_valid_r <= 1'b0;
      end else if (!lead_valid_r) begin
         lead_valid_r <= 1'b1;
         lead_ch_r <= !live[0];
      end
   end

   always_comb begin
      case (src_sel)
         ARCC_SRC_LAG: avail = (chan_en != 2'b00) && (live == chan_en);
         ARCC_SRC_OR: avail = live != 2'b00;
         ARCC_SRC_LEAD: avail = lead_valid_r ? live[lead_ch_r] :
                                               (live != 2'b00);
         default: avail = 1'b0;
      endcase
   end

   // idle level chosen by float bit
   // level or pulse on new data
   arcc_ready_pin u_pin (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .avail_in(avail),
      .pulse_fmt_in(ready_pin_mode_config_r[`ARCC_FMT_BIT]),
      .idle_float_in(ready_pin_mode_config_r[`ARCC_HIZ_BIT]),
      .pin_out(conversion_ready_pin_out),
      .pin_oe_out(conversion_ready_pin_oe_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // Rate and power decode for the converter.

   always_comb begin
      case (clock_channel_rate_config_r[`ARCC_OSR_HI:`ARCC_OSR_LO])
         3'b000: osr_nxt = `ARCC_OSR_0;
         3'b001: osr_nxt = `ARCC_OSR_1;
         3'b010: osr_nxt = `ARCC_OSR_2;
         3'b011: osr_nxt = `ARCC_OSR_3;
         3'b100: osr_nxt = `ARCC_OSR_4;
         3'b101: osr_nxt = `ARCC_OSR_5;
         3'b110: osr_nxt = `ARCC_OSR_6;
         default: osr_nxt = `ARCC_OSR_7;
      endcase
      if (clock_channel_rate_config_r[`ARCC_TBM_BIT]) begin
         osr_nxt = `ARCC_OSR_TURBO;
      end
   end

   always_comb begin
      case (clock_channel_rate_config_r[`ARCC_PWR_HI:`ARCC_PWR_LO])
         2'b00: pwr_sel = ARCC_PWR_VLP;
         2'b01: pwr_sel = ARCC_PWR_LP;
         default: pwr_sel = ARCC_PWR_HR;
      endcase
   end

   // Outputs are registered, so configuration reaches the converter one
   // cycle after the register write lands.
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         channel_enable_out <= 2'b11;
         osr_ratio_out <= `ARCC_OSR_3;
         power_mode_out <= ARCC_PWR_HR;
         data_flag_out <= 2'b00;
      end else begin
         channel_enable_out <= chan_en;
         osr_ratio_out <= osr_nxt;
         power_mode_out <= pwr_sel;
         data_flag_out <= flags;
      end
   end

endmodule

// ---- dv/arcc_assertions.sv ----
`timescale 1ns/10ps
`include "arcc_map.svh"
// Watches the top ports of the ready-pin and clock configuration bank.
module arcc_assertions (
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic s_axi_awvalid_in,
   input wire logic s_axi_awready_out,
   input wire logic s_axi_wvalid_in,
   input wire logic s_axi_wready_out,
   input wire logic s_axi_bvalid_out,
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic s_axi_rvalid_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic [1:0] conv_done_in,
   input wire logic data_read_in,
   input wire logic conversion_ready_pin_out,
   input wire logic conversion_ready_pin_oe_out,
   input wire logic [1:0] channel_enable_out,
   input wire logic [14:0] osr_ratio_out,
   input wire logic [1:0] power_mode_out,
   input wire logic [1:0] data_flag_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);
   logic [7:0] rd_addr_r;
   //////////////////////////////////////////////////////////////////////
   // The read data arrive after the address is gone, so keep it here.
   always_ff @(posedge sys_clk_in) begin
      if (s_axi_arvalid_in && s_axi_arready_out) begin
         rd_addr_r <= s_axi_araddr_in;
      end
   end
   //////////////////////////////////////////////////////////////////////
   AST_CLK_RSVD: assert property (
      s_axi_rvalid_out && rd_addr_r == `ARCC_ADDR_CLOCK
      |-> s_axi_rdata_out[15:10] == 6'h00)
      else $error("Clock register reserved bits not zero.");
   AST_PWR_CODE: assert property (
      power_mode_out != 2'h3) else $error("Power mode code 3 seen.");
   AST_OSR_SET: assert property (
      $onehot(osr_ratio_out) || osr_ratio_out == 15'h3f80)
      else $error("Ratio outside the documented set.");
   AST_FLOAT_HIGH: assert property (
      !conversion_ready_pin_oe_out |-> conversion_ready_pin_out)
      else $error("Floating pin not at idle level.");
   AST_NO_DATA: assert property (
      data_flag_out == 2'h0 [*4] |-> conversion_ready_pin_out)
      else $error("Ready pin low with no data.");
   AST_FLAG_SET: assert property (
      conv_done_in[0] && channel_enable_out[0] |-> ##2 data_flag_out[0])
      else $error("Channel zero flag not set.");
   AST_FLAG_CLR: assert property (
      data_read_in && conv_done_in == 2'h0 |-> ##2 data_flag_out == 2'h0)
      else $error("Flags not cleared by read.");
   AST_DIS_FLAG: assert property (
      !channel_enable_out[1] [*3] |-> !data_flag_out[1])
      else $error("Disabled channel shows a flag.");
   AST_RD_ANS: assert property (
      s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("Read answer late.");
   AST_WR_ANS: assert property (
      s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
      s_axi_wready_out |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out)
      else $error("Write answer not two edges on.");
endmodule

// ---- dv/arcc_conv_model.sv ----
`timescale 1ns/10ps
// Stand-in for the converter datapath that raises the done and read events.
module arcc_conv_model (
   input wire logic sys_clk_in,
   input wire logic [1:0] channel_enable_in,
   output logic [1:0] conv_done_out,
   output logic data_read_out
);
   // Quiet from time zero so the bank never sees an unknown event.
   initial begin
      conv_done_out = 2'h0;
      data_read_out = 1'b0;
   end
   // enabled channels only.
   // A disabled channel does not convert, so its pulse is dropped.
   task automatic finish(input logic [1:0] ch);
      @(posedge sys_clk_in);
      conv_done_out <= ch & channel_enable_in;
      @(posedge sys_clk_in);
      conv_done_out <= 2'h0;
   endtask
   // One-cycle read that consumes the data of both channels.
   task automatic fetch();
      @(posedge sys_clk_in);
      data_read_out <= 1'b1;
      @(posedge sys_clk_in);
      data_read_out <= 1'b0;
   endtask
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/10ps
`include "arcc_map.svh"
// Register bus and ready pin bench for the configuration bank.
module tb;
   logic sys_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [7:0] s_axi_awaddr_in = 8'h00;
   logic [7:0] s_axi_araddr_in = 8'h00;
   logic [31:0] s_axi_wdata_in = 32'h0;
   logic [3:0] s_axi_wstrb_in = 4'h3;
   logic s_axi_awvalid_in = 1'b0;
   logic s_axi_wvalid_in = 1'b0;
   logic s_axi_bready_in = 1'b0;
   logic s_axi_arvalid_in = 1'b0;
   logic s_axi_rready_in = 1'b0;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
   logic s_axi_arready_out, s_axi_rvalid_out;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, channel_enable_out;
   logic [1:0] conv_done_in, power_mode_out, data_flag_out;
   logic [31:0] s_axi_rdata_out;
   logic [14:0] osr_ratio_out;
   logic data_read_in, conversion_ready_pin_out, conversion_ready_pin_oe_out;
   int mismatches = 0;
   int checks_done = 0;
   logic [14:0] osr_tab [8] = '{15'h0080, 15'h0100, 15'h0200, 15'h0400,
      15'h0800, 15'h1000, 15'h2000, 15'h3f80};
   //////////////////////////////////////////////////////////////////////
   // Free-running 50 MHz clock.
   always #10 sys_clk_in = ~sys_clk_in;
   arcc_top arcc_top_i (.*);
   arcc_conv_model arcc_conv_model_i (
      .sys_clk_in(sys_clk_in),
      .channel_enable_in(channel_enable_out),
      .conv_done_out(conv_done_in),
      .data_read_out(data_read_in)
   );
   //////////////////////////////////////////////////////////////////////
   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask
   // Write with both channels offered together; ends one edge later so
   // that the next call never drives a signal twice in one time step.
   task automatic wr(input logic [7:0] a, input logic [15:0] d,
      input logic [1:0] er);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= {16'h0000, d};
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge sys_clk_in);
         if (!ad && s_axi_awready_out) begin
            ad = 1'b1;
            s_axi_awvalid_in <= 1'b0;
         end
         if (!wd && s_axi_wready_out) begin
            wd = 1'b1;
            s_axi_wvalid_in <= 1'b0;
         end
      end
      do @(posedge sys_clk_in); while (!s_axi_bvalid_out);
      s_axi_bready_in <= 1'b0;
      chk(32'(s_axi_bresp_out), 32'(er));
      @(posedge sys_clk_in);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= 1'b1;
      do @(posedge sys_clk_in); while (!s_axi_arready_out);
      s_axi_arvalid_in <= 1'b0;
      do @(posedge sys_clk_in); while (!s_axi_rvalid_out);
      s_axi_rready_in <= 1'b0;
      chk(s_axi_rdata_out, e);
      chk(32'(s_axi_rresp_out), 32'(er));
      @(posedge sys_clk_in);
   endtask
   task automatic summarize();
      $display("TB: %0d mismatches in %0d checks", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////
   // A hang is cut short well beyond the few hundred cycles needed.
   initial begin
      repeat (5000) @(posedge sys_clk_in);
      mismatches++;
      summarize();
   end
   // Main sequence of register and pin scenarios.
   initial begin
      int lows;
      repeat (8) @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      @(posedge sys_clk_in);
      rd(`ARCC_ADDR_MODE, 32'h0510, 2'h0);
      rd(`ARCC_ADDR_CLOCK, 32'h030e, 2'h0);
      rd(`ARCC_ADDR_STATUS, 32'h0, 2'h0);
      chk(32'(channel_enable_out), 32'h3);
      chk(32'(osr_ratio_out), 32'h0400);
      chk(32'(power_mode_out), 32'h2);
      chk(32'(conversion_ready_pin_oe_out), 32'h1);
      // Unmapped and read-only places answer with an error.
      wr(8'h40, 16'h0001, 2'h2);
      rd(8'h40, 32'h0, 2'h2);
      wr(`ARCC_ADDR_STATUS, 16'h0003, 2'h2);
      // Only the low byte lane lands when its strobe alone is set.
      s_axi_wstrb_in <= 4'h1;
      wr(`ARCC_ADDR_MODE, 16'hff1c, 2'h0);
      rd(`ARCC_ADDR_MODE, 32'h051c, 2'h0);
      s_axi_wstrb_in <= 4'h3;
      // Every ratio code and power code, reserved bits 7:6 kept zero.
      for (int c = 0; c < 8; c++) begin
         wr(`ARCC_ADDR_CLOCK, 16'h0300 | 16'(c << 2) | 16'(c & 3),
            2'h0);
         cyc(1);
         chk(32'(osr_ratio_out), 32'(osr_tab[c]));
         chk(32'(power_mode_out), ((c & 3) == 3) ? 2 : (c & 3));
      end
      wr(`ARCC_ADDR_CLOCK, 16'hfc23, 2'h0);
      rd(`ARCC_ADDR_CLOCK, 32'h0023, 2'h0);
      chk(32'(osr_ratio_out), 32'h0040);
      chk(32'(channel_enable_out), 32'h0);
      wr(`ARCC_ADDR_CLOCK, 16'h030e, 2'h0);
      // Each source select with channel zero finishing before one.
      for (int s = 0; s < 4; s++) begin
         wr(`ARCC_ADDR_MODE, 16'h0510 | 16'(s << 2), 2'h0);
         arcc_conv_model_i.finish(2'b01);
         cyc(3);
         chk(32'(data_flag_out), 32'h1);
         chk(32'(conversion_ready_pin_out), 32'(s == 0));
         arcc_conv_model_i.finish(2'b10);
         cyc(3);
         chk(32'(conversion_ready_pin_out), 32'h0);
         arcc_conv_model_i.fetch();
         cyc(3);
         chk(32'(conversion_ready_pin_out), 32'h1);
      end
      // Lagging select with channel one switched off.
      wr(`ARCC_ADDR_CLOCK, 16'h010e, 2'h0);
      wr(`ARCC_ADDR_MODE, 16'h0510, 2'h0);
      arcc_conv_model_i.finish(2'b01);
      cyc(3);
      chk(32'(conversion_ready_pin_out), 32'h0);
      // Channel one back on: the lagging source now waits for it too.
      wr(`ARCC_ADDR_CLOCK, 16'h030e, 2'h0);
      cyc(1);
      chk(32'(conversion_ready_pin_out), 32'h1);
      arcc_conv_model_i.finish(2'b10);
      cyc(2);
      rd(`ARCC_ADDR_STATUS, 32'h3, 2'h0);
      wr(`ARCC_ADDR_CLOCK, 16'h010e, 2'h0);
      cyc(2);
      chk(32'(data_flag_out), 32'h1);
      arcc_conv_model_i.fetch();
      cyc(3);
      // Floating idle level, driven low once data arrive.
      wr(`ARCC_ADDR_MODE, 16'h0512, 2'h0);
      cyc(2);
      chk(32'(conversion_ready_pin_oe_out), 32'h0);
      arcc_conv_model_i.finish(2'b01);
      cyc(3);
      chk(32'(conversion_ready_pin_oe_out), 32'h1);
      chk(32'(conversion_ready_pin_out), 32'h0);
      arcc_conv_model_i.fetch();
      cyc(3);
      chk(32'(conversion_ready_pin_oe_out), 32'h0);
      // Pulse format: a fixed two-cycle low pulse, then idle.
      wr(`ARCC_ADDR_MODE, 16'h0515, 2'h0);
      arcc_conv_model_i.finish(2'b01);
      lows = 0;
      repeat (8) begin
         @(posedge sys_clk_in);
         lows += int'(conversion_ready_pin_out === 1'b0);
      end
      chk(32'(lows), 32'h2);
      arcc_conv_model_i.fetch();
      summarize();
   end
endmodule
bind arcc_top arcc_assertions arcc_assertions_i (.*);
